//--- escsw_pkg.sv
// Purpose: shared constants and carriers for the stream sideband framer
// Assumes: 32-bit stream buses, one clock for all buses
// Notes:   control and status transfers are six words each
`default_nettype none
package escsw_pkg;
  // flag nibble codes and position
  localparam logic [3:0] FLAG_NORMAL = 4'hA;
  localparam logic [3:0] FLAG_RXSTS  = 4'h5;
  localparam int         FLAG_LSB    = 28;
  // checksum select codes in control word 1
  localparam logic [1:0] CSUM_NONE    = 2'h0;
  localparam logic [1:0] CSUM_PARTIAL = 2'h1;
  localparam logic [1:0] CSUM_FULL    = 2'h2;
  // build option values for the offload engines
  localparam int OPT_TX_PARTIAL = 1;
  localparam int OPT_TX_FULL    = 2;
  localparam int OPT_RX_RAW     = 1;
  // word indices within a six-word sideband transfer
  localparam logic [2:0] WORD0    = 3'h0;
  localparam logic [2:0] WORD1    = 3'h1;
  localparam logic [2:0] WORD2    = 3'h2;
  localparam logic [2:0] WORD3    = 3'h3;
  localparam logic [2:0] WORD4    = 3'h4;
  localparam logic [2:0] WORD_END = 3'h5;
  // byte strobes
  localparam logic [3:0] KEEP_ALL = 4'hF;
  localparam logic [3:0] KEEP_1   = 4'h1;
  localparam logic [3:0] KEEP_2   = 4'h3;
  localparam logic [3:0] KEEP_3   = 4'h7;
  // transmit fifo shape
  localparam int TXF_DEPTH = 16;
  // per-frame transmit settings handed to the mac
  typedef struct packed {
    logic        partial;
    logic        full;
    logic        loopback;
    logic [15:0] startOff;
    logic [15:0] writeOff;
    logic [15:0] seed;
  } escsw_tx_info_s;
  // per-frame receive results from the mac
  typedef struct packed {
    logic [15:0] len;
    logic [15:0] mcastUpper;
    logic        mcastHit;
    logic [15:0] rawCsum;
  } escsw_rx_info_s;
  // one data beat
  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  keep;
    logic        last;
  } escsw_beat_s;
endpackage
`default_nettype wire

//--- escsw_top.sv
// Purpose: sideband control decode (tx) and status framing (rx) for 32-bit streams
// Assumes: all stream buses share clk_sys; checksum arithmetic lives in the mac
// Notes:   a 16-word fifo buffers transmit data toward the mac
// Operation
// - control word 0 top nibble gives type
// - control word 1 bits 1:0 select checksum
// - partial offload only with tx option 1
// - full offload only with tx option 2
// - word 2 upper half is checksum start
// - word 3 low half is checksum seed
// - flag 5 sends looped frame, ignores status
// - looped frames get no offload or vlan
// - receive status has one fixed format
// - status stream starts before data stream
// - status and data throttle independently
// - rx data waits until status fully taken
// - status transfer is exactly six words
// - rx option 0 zeroes word 4 low
// - rx option 1 reports raw checksum
// - word 5 low half is frame length
// - last data strobes packed from lsb
// - status word 0 flag nibble is 5
// - word 1 low holds multicast upper bits
// - control transfers are six words, 0-3 used
// - data waits for control, control waits data
// - unknown control flags are ignored
`timescale 1ns/1ns
`default_nettype none

// simple synchronous fifo, valid/ready on both sides
module escsw_fifo #(
  parameter int WIDTH = 37,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  // fill side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // drain side
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  // pointers carry one extra wrap bit for honest full/empty
  typedef struct packed {
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
  } escsw_fifo_s;
  escsw_fifo_s             st;      // registered state
  escsw_fifo_s             nxt_st;  // next state
  logic        [WIDTH-1:0] mem [DEPTH];
  logic                    full;
  logic                    empty;
  logic                    push;
  logic                    pop;

  assign empty    = st.wrPtr == st.rdPtr;
  assign full     = (st.wrPtr[AW-1:0] == st.rdPtr[AW-1:0]) && (st.wrPtr[AW] != st.rdPtr[AW]);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[st.rdPtr[AW-1:0]];
  assign push     = inValid && !full;
  assign pop      = outReady && !empty;

  // pointer advance
  always_comb begin
    nxt_st = st;
    if (push) begin
      nxt_st.wrPtr = st.wrPtr + 1'b1;
    end
    if (pop) begin
      nxt_st.rdPtr = st.rdPtr + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= nxt_st;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[st.wrPtr[AW-1:0]] <= inData;
    end
  end
endmodule

module escsw_top
  import escsw_pkg::*;
#(
  parameter int TX_OFFLOAD_BUILD_OPTION = 0,
  parameter int RX_OFFLOAD_BUILD_OPTION = 0
) (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  // transmit control stream in
  input  wire logic [31:0]              txcTdata,
  input  wire logic                     txcTvalid,
  input  wire logic                     txcTlast,
  output logic                          txcTready,
  // transmit data stream in
  input  wire logic [31:0]              txdTdata,
  input  wire logic [3:0]               txdTkeep,
  input  wire logic                     txdTvalid,
  input  wire logic                     txdTlast,
  output logic                          txdTready,
  // transmit frame toward the mac
  output escsw_pkg::escsw_beat_s        macTxBeat,
  output logic                          macTxValid,
  input  wire logic                     macTxReady,
  output escsw_pkg::escsw_tx_info_s     macTxInfo,
  // receive results and data from the mac
  input  wire escsw_pkg::escsw_rx_info_s rxInfo,
  input  wire logic                     rxInfoValid,
  output logic                          rxInfoReady,
  input  wire logic [31:0]              rxInData,
  input  wire logic                     rxInValid,
  input  wire logic                     rxInLast,
  output logic                          rxInReady,
  // receive status stream out
  output logic [31:0]                   rxsTdata,
  output logic                          rxsTvalid,
  output logic                          rxsTlast,
  input  wire logic                     rxsTready,
  // receive data stream out
  output logic [31:0]                   rxdTdata,
  output logic [3:0]                    rxdTkeep,
  output logic                          rxdTvalid,
  output logic                          rxdTlast,
  input  wire logic                     rxdTready
);
  import escsw_pkg::*;

  // one-hot sequencers
  typedef enum logic [1:0] {TX_CTRL = 2'b01, TX_DATA = 2'b10} escsw_tx_e;
  typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_STS = 3'b010, RX_DATA = 3'b100} escsw_rx_e;

  typedef struct packed {
    escsw_tx_e      txState;
    logic [2:0]     ctrlCnt;   // control word index
    logic [3:0]     flag;      // flag of control in flight
    logic [1:0]     sel;       // checksum select
    logic [15:0]    startOff;
    logic [15:0]    writeOff;
    logic [15:0]    seed;
    escsw_tx_info_s info;      // published frame settings
    escsw_rx_e      rxState;
    logic [2:0]     stsCnt;    // status word index
    escsw_rx_info_s rx;        // captured receive results
    logic [31:0]    stsData;
    logic           stsValid;
    escsw_beat_s    rxd;
    logic           rxdValid;
  } escsw_top_s;

  localparam escsw_top_s ST_RESET = '{txState: TX_CTRL, rxState: RX_IDLE, default: '0};

  escsw_top_s  st;          // registered state
  escsw_top_s  nxt_st;      // next state
  escsw_beat_s fifoIn;
  logic        fifoInReady;
  logic        ctrlTake;
  logic        dataTake;
  logic        rxTake;
  logic [3:0]  flagNow;

  // strobes on the final beat from the low length bits
  function automatic logic [3:0] keepFromLen(input logic [1:0] lenLo);
    unique case (lenLo)
      2'h1:    keepFromLen = KEEP_1;
      2'h2:    keepFromLen = KEEP_2;
      2'h3:    keepFromLen = KEEP_3;
      default: keepFromLen = KEEP_ALL;
    endcase
  endfunction

  // the one status layout; reserved fields drive zero
  function automatic logic [31:0] stsWord(input logic [2:0] idx, input escsw_rx_info_s r);
    stsWord = '0;
    unique case (idx)
      WORD0:   stsWord[31:FLAG_LSB] = FLAG_RXSTS;
      WORD1:   stsWord[15:0] = r.mcastUpper;
      WORD2:   stsWord[0] = r.mcastHit;
      WORD4:   stsWord[15:0] = (RX_OFFLOAD_BUILD_OPTION == OPT_RX_RAW) ? r.rawCsum : '0;
      WORD_END: stsWord[15:0] = r.len;
      default: stsWord = '0;
    endcase
  endfunction

  // handshakes
  assign txcTready   = st.txState == TX_DATA ? 1'b0 : 1'b1;
  assign txdTready   = (st.txState == TX_DATA) && fifoInReady;
  assign ctrlTake    = txcTvalid && txcTready;
  assign dataTake    = txdTvalid && txdTready;
  assign flagNow     = (st.ctrlCnt == WORD0) ? txcTdata[31:FLAG_LSB] : st.flag;
  assign rxInfoReady = st.rxState == RX_IDLE;
  // data leaves only after the whole status transfer is taken
  // a beat of the next frame must not slip in behind the held last beat
  assign rxInReady   = (st.rxState == RX_DATA)
                       && (!st.rxdValid || (rxdTready && !st.rxd.last));
  assign rxTake      = rxInValid && rxInReady;
  assign macTxInfo   = st.info;
  assign rxsTdata    = st.stsData;
  assign rxsTvalid   = st.stsValid;
  assign rxsTlast    = st.stsValid && (st.stsCnt == WORD_END);
  assign rxdTdata    = st.rxd.data;
  assign rxdTkeep    = st.rxd.keep;
  assign rxdTlast    = st.rxd.last;
  assign rxdTvalid   = st.rxdValid;
  // mac ignores tx keep except on the last beat, passed as given
  assign fifoIn      = '{data: txdTdata, keep: txdTkeep, last: txdTlast};

  // next-state logic for both directions
  always_comb begin
    nxt_st = st;
    // transmit control decode
    unique case (st.txState)
      TX_CTRL: begin
        if (ctrlTake) begin
          if (st.ctrlCnt != WORD_END) begin
            nxt_st.ctrlCnt = st.ctrlCnt + 3'h1;
          end
          // words past 3 are accepted and dropped
          unique case (st.ctrlCnt)
            WORD0: nxt_st.flag = txcTdata[31:FLAG_LSB];
            WORD1: nxt_st.sel = txcTdata[1:0];
            WORD2: begin
              nxt_st.startOff = txcTdata[31:16];
              nxt_st.writeOff = txcTdata[15:0];
            end
            WORD3: nxt_st.seed = txcTdata[15:0];
            default: nxt_st.seed = st.seed;
          endcase
          if (txcTlast) begin
            nxt_st.ctrlCnt = WORD0;
            if (flagNow == FLAG_NORMAL || flagNow == FLAG_RXSTS) begin
              nxt_st.txState = TX_DATA;
              nxt_st.info.loopback = flagNow == FLAG_RXSTS;
              // looped frames never get offload
              // a short transfer publishes what it brought, including this word
              nxt_st.info.partial = flagNow == FLAG_NORMAL && nxt_st.sel == CSUM_PARTIAL
                                    && TX_OFFLOAD_BUILD_OPTION == OPT_TX_PARTIAL;
              nxt_st.info.full = flagNow == FLAG_NORMAL && nxt_st.sel == CSUM_FULL
                                 && TX_OFFLOAD_BUILD_OPTION == OPT_TX_FULL;
              nxt_st.info.startOff = nxt_st.startOff;
              nxt_st.info.writeOff = nxt_st.writeOff;
              nxt_st.info.seed = nxt_st.seed;
            end
          end
        end
      end
      TX_DATA: begin
        if (dataTake && txdTlast) begin
          nxt_st.txState = TX_CTRL;
        end
      end
      default: nxt_st.txState = TX_CTRL;
    endcase
    // receive status then data
    unique case (st.rxState)
      RX_IDLE: begin
        if (rxInfoValid) begin
          nxt_st.rx = rxInfo;
          nxt_st.stsCnt = WORD0;
          nxt_st.stsData = stsWord(WORD0, rxInfo);
          nxt_st.stsValid = 1'b1;
          nxt_st.rxState = RX_STS;
        end
      end
      RX_STS: begin
        // only the status ready throttles this phase
        if (st.stsValid && rxsTready) begin
          if (st.stsCnt == WORD_END) begin
            nxt_st.stsValid = 1'b0;
            nxt_st.rxState = RX_DATA;
          end else begin
            nxt_st.stsCnt = st.stsCnt + 3'h1;
            nxt_st.stsData = stsWord(st.stsCnt + 3'h1, st.rx);
          end
        end
      end
      RX_DATA: begin
        // output stage throttled only by the data ready
        if (st.rxdValid && rxdTready) begin
          nxt_st.rxdValid = 1'b0;
          if (st.rxd.last) begin
            nxt_st.rxState = RX_IDLE;
          end
        end
        if (rxTake) begin
          nxt_st.rxdValid = 1'b1;
          nxt_st.rxd.data = rxInData;
          nxt_st.rxd.last = rxInLast;
          nxt_st.rxd.keep = rxInLast ? keepFromLen(st.rx.len[1:0]) : KEEP_ALL;
        end
      end
      default: nxt_st.rxState = RX_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= ST_RESET;
    end else begin
      st <= nxt_st;
    end
  end

  // transmit data buffer toward the mac
  escsw_fifo #(.WIDTH($bits(escsw_beat_s)), .DEPTH(TXF_DEPTH)) u_txFifo (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .inData   (fifoIn),
    .inValid  (txdTvalid && st.txState == TX_DATA),
    .inReady  (fifoInReady),
    .outData  (macTxBeat),
    .outValid (macTxValid),
    .outReady (macTxReady)
  );

  // checks
  a_txd_gated: assert property (@(posedge clk_sys) disable iff (!rst_b)
    txdTready |-> (st.txState == TX_DATA) && !txcTready)
    else $error("tx data ready outside data phase");
  a_bad_flag_drop: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ctrlTake && txcTlast && flagNow != FLAG_NORMAL && flagNow != FLAG_RXSTS
    |=> st.txState == TX_CTRL && txcTready)
    else $error("reserved control flag not ignored");
  a_partial_opt: assert property (@(posedge clk_sys) disable iff (!rst_b)
    macTxInfo.partial |-> TX_OFFLOAD_BUILD_OPTION == OPT_TX_PARTIAL && !macTxInfo.loopback)
    else $error("partial offload without build option");
  a_full_opt: assert property (@(posedge clk_sys) disable iff (!rst_b)
    macTxInfo.full |-> TX_OFFLOAD_BUILD_OPTION == OPT_TX_FULL && !macTxInfo.partial)
    else $error("full offload without build option");
  a_loop_plain: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ctrlTake && txcTlast && flagNow == FLAG_RXSTS
    |=> macTxInfo.loopback && !macTxInfo.partial && !macTxInfo.full)
    else $error("looped frame got offload");
  a_sts_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rxsTvalid && st.stsCnt == WORD0 |-> rxsTdata[31:FLAG_LSB] == FLAG_RXSTS)
    else $error("status flag nibble wrong");
  a_sts_six: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rxInfoValid && rxInfoReady ##1 rxsTready [*6]
    |=> !rxsTvalid && $past(rxsTlast) && !$past(rxsTlast, 2))
    else $error("status not six words");
  a_sts_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rxsTvalid && !rxsTready |=> rxsTvalid && $stable(rxsTdata))
    else $error("status dropped under back-pressure");
  a_data_after: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rxInReady |-> !rxsTvalid && st.rxState == RX_DATA)
    else $error("rx data moved before status done");
  a_csum_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rxsTvalid && st.stsCnt == WORD4 && RX_OFFLOAD_BUILD_OPTION == 0 |-> rxsTdata[15:0] == 16'h0)
    else $error("checksum word not zero");
  a_len_word: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rxsTlast |-> rxsTdata[15:0] == st.rx.len)
    else $error("length word mismatch");
  a_last_keep: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rxdTvalid && rxdTlast |-> rxdTkeep == keepFromLen(st.rx.len[1:0]))
    else $error("last strobes wrong");
endmodule
`default_nettype wire

//--- escsw_sink_model.sv
// Purpose: receive-side sink standing in for the dma engine
// Assumes: status and data buses share clk_sys
// Notes:   slow mode stalls each bus on its own pattern
`timescale 1ns/1ns
`default_nettype none
module escsw_sink_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // bench controls
  input  wire logic        slow,
  input  wire logic        clr,
  // status stream
  input  wire logic [31:0] rxsTdata,
  input  wire logic        rxsTvalid,
  input  wire logic        rxsTlast,
  output logic             rxsTready,
  // data stream
  input  wire logic [31:0] rxdTdata,
  input  wire logic [3:0]  rxdTkeep,
  input  wire logic        rxdTvalid,
  input  wire logic        rxdTlast,
  output logic             rxdTready
);
  logic [31:0] sts [0:7];   // captured status words
  logic [31:0] dat [0:31];  // captured data words
  int          stsN;        // status words taken
  int          datN;        // data words taken
  int          lastIdx;     // index of the word carrying last
  int          cyc;         // free cycle count for stall patterns
  logic [3:0]  lastKeep;    // strobes of the newest data beat
  logic        stsDone;     // whole status frame taken
  logic        early;       // data offered before status ended
  // stall patterns differ per bus so neither can lean on the other
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cyc <= 0;
      rxsTready <= 1'h1;
      rxdTready <= 1'h1;
    end else begin
      cyc <= cyc + 1;
      rxsTready <= !slow || cyc[0];
      rxdTready <= !slow || !cyc[1];
    end
  end
  // record what each bus hands over
  always @(posedge clk_sys) begin
    if (clr) begin
      stsN <= 0;
      datN <= 0;
      stsDone <= 1'h0;
      early <= 1'h0;
    end else begin
      if (rxsTvalid && rxsTready) begin
        sts[stsN % 8] <= rxsTdata;
        stsN <= stsN + 1;
        if (rxsTlast) begin
          lastIdx <= stsN;
          stsDone <= 1'h1;
        end
      end
      if (rxdTvalid && rxdTready) begin
        dat[datN % 32] <= rxdTdata;
        datN <= datN + 1;
        lastKeep <= rxdTkeep;
      end
      // data must not even be offered before the status frame ends
      if (rxdTvalid && !stsDone) begin
        early <= 1'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- test_eth_stream_ctrl_status_words.sv
// Purpose: self-checking bench for the sideband framer
// Assumes: main build tx partial, rx raw; second build tx full, rx off
// Notes:   inputs change at falling edges only
`timescale 1ns/1ns
`default_nettype none
module test_eth_stream_ctrl_status_words;
  import escsw_pkg::*;
  // clock, reset and sink controls
  logic           clk_sys = 1'h0;
  logic           rst_b = 1'h0;
  logic           slow = 1'h0;
  logic           clr = 1'h1;
  // transmit side
  logic [31:0]    txcTdata = '0, txdTdata = '0;
  logic [3:0]     txdTkeep = '0;
  logic           txcTvalid = 1'h0, txcTlast = 1'h0, txdTvalid = 1'h0, txdTlast = 1'h0;
  logic           macTxReady = 1'h1;
  logic           txcTready, txdTready, macTxValid;
  escsw_beat_s    macTxBeat;
  escsw_tx_info_s macTxInfo;
  // receive side
  escsw_rx_info_s rxInfo = '0;
  logic [31:0]    rxInData = '0, rxsTdata, rxdTdata;
  logic           rxInfoValid = 1'h0, rxInValid = 1'h0, rxInLast = 1'h0;
  logic           rxInfoReady, rxInReady, rxsTvalid, rxsTlast, rxsTready;
  logic           rxdTvalid, rxdTlast, rxdTready;
  logic [3:0]     rxdTkeep;
  // second build outputs that differ from the main build
  escsw_tx_info_s altTxInfo;
  logic [31:0]    altRxsTdata, altSts4;
  // bookkeeping
  int             mismatches = 0;
  int             nChecks = 0;
  escsw_beat_s    seen[$], expq[$];

  escsw_top #(
    .TX_OFFLOAD_BUILD_OPTION(OPT_TX_PARTIAL),
    .RX_OFFLOAD_BUILD_OPTION(OPT_RX_RAW)
  ) i_dut (
    .clk_sys, .rst_b, .txcTdata, .txcTvalid, .txcTlast, .txcTready,
    .txdTdata, .txdTkeep, .txdTvalid, .txdTlast, .txdTready,
    .macTxBeat, .macTxValid, .macTxReady, .macTxInfo,
    .rxInfo, .rxInfoValid, .rxInfoReady, .rxInData, .rxInValid, .rxInLast, .rxInReady,
    .rxsTdata, .rxsTvalid, .rxsTlast, .rxsTready,
    .rxdTdata, .rxdTkeep, .rxdTvalid, .rxdTlast, .rxdTready
  );
  // second build shares every input; its handshakes match the main build
  escsw_top #(
    .TX_OFFLOAD_BUILD_OPTION(OPT_TX_FULL),
    .RX_OFFLOAD_BUILD_OPTION(0)
  ) i_dut_full (
    .clk_sys, .rst_b, .txcTdata, .txcTvalid, .txcTlast, .txcTready(),
    .txdTdata, .txdTkeep, .txdTvalid, .txdTlast, .txdTready(),
    .macTxBeat(), .macTxValid(), .macTxReady, .macTxInfo(altTxInfo),
    .rxInfo, .rxInfoValid, .rxInfoReady(), .rxInData, .rxInValid, .rxInLast, .rxInReady(),
    .rxsTdata(altRxsTdata), .rxsTvalid(), .rxsTlast(), .rxsTready,
    .rxdTdata(), .rxdTkeep(), .rxdTvalid(), .rxdTlast(), .rxdTready
  );
  // second build's status word 4, taken with the main build's word 4
  always @(posedge clk_sys) begin
    if (rxsTvalid && rxsTready && i_sink.stsN == 4) begin
      altSts4 <= altRxsTdata;
    end
  end
  escsw_sink_model i_sink (
    .clk_sys, .rst_b, .slow, .clr, .rxsTdata, .rxsTvalid, .rxsTlast, .rxsTready,
    .rxdTdata, .rxdTkeep, .rxdTvalid, .rxdTlast, .rxdTready
  );

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;
  // every beat the mac takes, in order
  always @(posedge clk_sys) begin
    if (macTxValid && macTxReady) begin
      seen.push_back(macTxBeat);
    end
  end

  task automatic print_verdict;
    if (mismatches == 0 && nChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [36:0] got, input logic [36:0] exp, input string what);
    nChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  // a wait that ran out ends the run
  task automatic give_up;
    chk(37'h0, 37'h1, "wait timed out");
    print_verdict();
  endtask
  function automatic logic rdy(input int w);
    case (w)
      0: return txcTready;
      1: return txdTready;
      2: return rxInfoReady;
      default: return rxInReady;
    endcase
  endfunction
  // request already driven; wait for ready, then let the taking edge pass
  task automatic hs(input int w);
    int n;
    n = 0;
    while (rdy(w) !== 1'h1) begin
      @(negedge clk_sys);
      n++;
      if (n > 300) begin
        give_up();
      end
    end
    @(negedge clk_sys);
  endtask

  // one control transfer, then nb data beats when the flag is a known one
  task automatic tx_frame(input logic [3:0] flag, input logic [1:0] sel, input int nb,
                          input logic hold);
    logic [31:0] w [0:5];
    logic        good;
    escsw_beat_s b;
    int          i;
    w[0] = {flag, 28'h0};
    w[1] = {30'h0, sel};
    w[2][31:16] = {9'h0, sel, flag, 1'h0};
    w[2][15:0] = w[2][31:16] + 16'h000A;
    w[3] = {16'hFFFF, flag, 10'h0, sel};
    w[4] = 32'hDEADBEEF;
    w[5] = 32'hC0FFEE00;
    good = (flag == FLAG_NORMAL) || (flag == FLAG_RXSTS);
    for (i = 0; i < 6; i++) begin
      chk(txdTready, 1'h0, "data ready during ctrl");
      txcTdata = w[i];
      txcTvalid = 1'h1;
      txcTlast = (i == 5);
      hs(0);
    end
    txcTvalid = 1'h0;
    txcTlast = 1'h0;
    macTxReady = !hold;
    chk(txcTready, !good, "ctrl ready after ctrl");
    chk(txdTready, good, "data ready after ctrl");
    if (good) begin
      chk(macTxInfo.partial, sel == CSUM_PARTIAL && flag == FLAG_NORMAL, "partial");
      chk(macTxInfo.full, 1'h0, "full");
      chk({altTxInfo.partial, altTxInfo.full}, {1'h0, sel == CSUM_FULL && flag == FLAG_NORMAL},
          "full build offload");
      chk(macTxInfo.loopback, flag == FLAG_RXSTS, "loopback");
      chk({macTxInfo.startOff, macTxInfo.seed}, {w[2][31:16], w[3][15:0]}, "start");
      chk(macTxInfo.writeOff, w[2][15:0], "write offset");
      for (i = 0; i < nb; i++) begin
        b.data = {w[2][15:0], 11'h0, i[4:0]};
        b.last = (i == nb - 1);
        b.keep = b.last ? KEEP_1 : KEEP_ALL;
        expq.push_back(b);
        // far side stalled: the fifo must refuse beat seventeen
        if (hold && i == TXF_DEPTH) begin
          chk(txdTready, 1'h0, "fifo full");
          macTxReady = 1'h1;
        end
        {txdTdata, txdTkeep, txdTlast} = b;
        txdTvalid = 1'h1;
        hs(1);
      end
      txdTvalid = 1'h0;
      txdTlast = 1'h0;
      chk(txcTready, 1'h1, "ctrl ready after data");
    end
  endtask

  // one received frame of len bytes through status and data streams
  task automatic rx_frame(input logic [15:0] len, input logic sl);
    int         i;
    int         nb;
    logic [3:0] k;
    nb = (len + 3) / 4;
    slow = sl;
    clr = 1'h1;
    @(negedge clk_sys);
    clr = 1'h0;
    rxInfo = '{len: len, mcastUpper: 16'hFFEE ^ len, mcastHit: len[0], rawCsum: ~len};
    rxInfoValid = 1'h1;
    hs(2);
    rxInfoValid = 1'h0;
    for (i = 0; i < nb; i++) begin
      rxInData = {len, i[15:0]};
      rxInValid = 1'h1;
      rxInLast = (i == nb - 1);
      hs(3);
    end
    rxInValid = 1'h0;
    rxInLast = 1'h0;
    for (i = 0; i < 300 && i_sink.datN < nb; i++) begin
      @(negedge clk_sys);
    end
    if (i == 300) begin
      give_up();
    end
    k = len[1:0] == 2'h1 ? KEEP_1 : len[1:0] == 2'h2 ? KEEP_2 : len[1:0] == 2'h3 ? KEEP_3 : KEEP_ALL;
    chk(i_sink.stsN, 6, "status words");
    chk(i_sink.lastIdx, 5, "status last");
    chk(i_sink.sts[0][31:28], FLAG_RXSTS, "status flag");
    chk(i_sink.sts[1][15:0], rxInfo.mcastUpper, "mcast upper");
    chk(i_sink.sts[2][0], rxInfo.mcastHit, "mcast hit");
    chk(i_sink.sts[4][15:0], rxInfo.rawCsum, "raw checksum");
    chk(altSts4[15:0], 16'h0000, "checksum word zero");
    chk(i_sink.sts[5][15:0], len, "length");
    chk(i_sink.lastKeep, k, "last keep");
    chk(i_sink.dat[nb - 1], {len, 16'(nb - 1)}, "last data");
    chk(i_sink.early, 1'h0, "data before status");
  endtask

  // main sequence
  initial begin
    logic [3:0]  flags [0:2];
    logic [15:0] lens [0:4];
    int          n;
    flags = '{FLAG_NORMAL, FLAG_RXSTS, 4'h3};
    lens = '{16'h0001, 16'h0006, 16'h0007, 16'h0008, 16'h0041};
    repeat (2) @(negedge clk_sys);
    chk({txcTready, txdTready, rxInfoReady, rxInReady, macTxValid, rxsTvalid, rxdTvalid},
        7'h50, "reset values");
    rst_b = 1'h1;
    @(negedge clk_sys);
    foreach (flags[f]) begin
      for (n = 0; n < 4; n++) begin
        tx_frame(flags[f], n[1:0], 3, 1'h0);
      end
    end
    tx_frame(FLAG_NORMAL, CSUM_FULL, TXF_DEPTH + 4, 1'h1);
    for (n = 0; n < 300 && seen.size() < expq.size(); n++) begin
      @(negedge clk_sys);
    end
    if (n == 300) begin
      give_up();
    end
    chk(seen.size(), expq.size(), "mac beat count");
    foreach (expq[j]) begin
      chk(seen[j], expq[j], "mac beat");
    end
    foreach (lens[j]) begin
      rx_frame(lens[j], j[0]);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
